// ===== hw/stepper_driver_status_bank.sv
`timescale 1ns/1ps
module stepper_driver_status_bank
(
    input  wire logic                                   clock,
    input  wire logic                                   resetn,
    input  wire logic                                   regRead,
    input  wire logic [stepper_status_pkg::ADDR_W-1:0]  regAddr,
    output logic      [stepper_status_pkg::DATA_W-1:0]  readData,
    output logic                                        readValid,
    input  wire logic                                   thermal_warning_flag,
    input  wire logic                                   charge_pump_failure_flag,
    input  wire logic                                   open_coil_x_flag,
    input  wire logic                                   open_coil_y_flag,
    input  wire logic                                   overcurrent_x_pos_top,
    input  wire logic                                   overcurrent_x_pos_bottom,
    input  wire logic                                   overcurrent_x_neg_top,
    input  wire logic                                   overcurrent_x_neg_bottom,
    input  wire logic                                   overcurrent_y_pos_top,
    input  wire logic                                   overcurrent_y_pos_bottom,
    input  wire logic                                   overcurrent_y_neg_top,
    input  wire logic                                   overcurrent_y_neg_bottom,
    input  wire logic                                   thermal_shutdown_flag,
    input  wire logic                                   watchdogExpired,
    input  wire logic                                   watchdogEnableWriteZero,
    input  wire logic [stepper_status_pkg::STEP_W-1:0]  micro_step_position,
    output logic                                        watchdog_event_flag
);
    // All state of the bank outside the two synchroniser stages in u_sync lives in one register, so reset covers every bit at once.
    typedef struct packed
    {
        logic [3:0]                              ovcX;
        logic [3:0]                              ovcY;
        logic                                    hotStop;
        logic                                    dogEvent;
        logic [stepper_status_pkg::DATA_W-1:0]   rdata;
        logic                                    rvalid;
    } bank_s;

    bank_s state_q;
    bank_s state_d;

    fault_sync_if faults ();

    // Each fault lands on its named lane, so the lane map lives in one place only.
    always_comb
    begin
        faults.raw                                     = stepper_status_pkg::SYNC_RESET;
        faults.raw[stepper_status_pkg::S_WARN]         = thermal_warning_flag;
        faults.raw[stepper_status_pkg::S_PUMP]         = charge_pump_failure_flag;
        faults.raw[stepper_status_pkg::S_COIL_X]       = open_coil_x_flag;
        faults.raw[stepper_status_pkg::S_COIL_Y]       = open_coil_y_flag;
        faults.raw[stepper_status_pkg::S_OVCX]         = overcurrent_x_pos_top;
        faults.raw[stepper_status_pkg::S_OVCX+1]       = overcurrent_x_pos_bottom;
        faults.raw[stepper_status_pkg::S_OVCX+2]       = overcurrent_x_neg_top;
        faults.raw[stepper_status_pkg::S_OVCX+3]       = overcurrent_x_neg_bottom;
        faults.raw[stepper_status_pkg::S_OVCY]         = overcurrent_y_pos_top;
        faults.raw[stepper_status_pkg::S_OVCY+1]       = overcurrent_y_pos_bottom;
        faults.raw[stepper_status_pkg::S_OVCY+2]       = overcurrent_y_neg_top;
        faults.raw[stepper_status_pkg::S_OVCY+3]       = overcurrent_y_neg_bottom;
        faults.raw[stepper_status_pkg::S_SHUTDOWN]     = thermal_shutdown_flag;
    end

    fault_synchronizer u_sync
    (
        .clock  (clock),
        .resetn (resetn),
        .bus    (faults.syncer)
    );

    logic [3:0]                            ovcXNow;
    logic [3:0]                            ovcYNow;
    logic [stepper_status_pkg::DATA_W-1:0] word0;
    logic [stepper_status_pkg::DATA_W-1:0] word1;
    logic [stepper_status_pkg::DATA_W-1:0] word2;
    logic [stepper_status_pkg::DATA_W-1:0] word3;
    logic [stepper_status_pkg::DATA_W-1:0] readWord;
    logic                                  clearX;
    logic                                  clearY;

    // Parity is worked out from the value handed back, never stored beside it.
    function automatic logic [stepper_status_pkg::DATA_W-1:0] with_parity
    (
        input logic [stepper_status_pkg::DATA_W-2:0] body
    );
        return {^body, body};
    endfunction : with_parity

    // Bit order inside each nibble is top-positive, bottom-positive, top-negative, bottom-negative.
    always_comb
    begin
        ovcXNow[3] = faults.synced[stepper_status_pkg::S_OVCX];
        ovcXNow[2] = faults.synced[stepper_status_pkg::S_OVCX+1];
        ovcXNow[1] = faults.synced[stepper_status_pkg::S_OVCX+2];
        ovcXNow[0] = faults.synced[stepper_status_pkg::S_OVCX+3];
        ovcYNow[3] = faults.synced[stepper_status_pkg::S_OVCY];
        ovcYNow[2] = faults.synced[stepper_status_pkg::S_OVCY+1];
        ovcYNow[1] = faults.synced[stepper_status_pkg::S_OVCY+2];
        ovcYNow[0] = faults.synced[stepper_status_pkg::S_OVCY+3];
    end

    always_comb
    begin
        word0 = stepper_status_pkg::STATUS_RESET;
        word0[stepper_status_pkg::WARN_BIT]   = faults.synced[stepper_status_pkg::S_WARN];
        word0[stepper_status_pkg::PUMP_BIT]   = faults.synced[stepper_status_pkg::S_PUMP];
        word0[stepper_status_pkg::DOG_BIT]    = state_q.dogEvent;
        word0[stepper_status_pkg::COIL_X_BIT] = faults.synced[stepper_status_pkg::S_COIL_X];
        word0[stepper_status_pkg::COIL_Y_BIT] = faults.synced[stepper_status_pkg::S_COIL_Y];
        word0 = with_parity(word0[6:0]);

        word1 = stepper_status_pkg::STATUS_RESET;
        word1[stepper_status_pkg::OVC_LSB +: 4] = state_q.ovcX;
        word1 = with_parity(word1[6:0]);

        word2 = stepper_status_pkg::STATUS_RESET;
        word2[stepper_status_pkg::OVC_LSB +: 4]      = state_q.ovcY;
        word2[stepper_status_pkg::SHUTDOWN_BIT]      = state_q.hotStop;
        word2 = with_parity(word2[6:0]);

        word3 = with_parity(micro_step_position);
    end

    // Decode is kept apart from the latch update; an unmapped address reads as zero.
    always_comb
    begin
        readWord = stepper_status_pkg::STATUS_RESET;
        clearX   = 1'b0;
        clearY   = 1'b0;
        unique case (regAddr)
            stepper_status_pkg::FAULT_AND_WATCHDOG_STATUS_OFS:
            begin
                readWord = word0;
            end
            stepper_status_pkg::PHASE_X_OVERCURRENT_STATUS_OFS:
            begin
                readWord = word1;
                clearX   = regRead;
            end
            stepper_status_pkg::PHASE_Y_OVERCURRENT_STATUS_OFS:
            begin
                readWord = word2;
                clearY   = regRead;
            end
            stepper_status_pkg::STEP_POSITION_STATUS_OFS:
            begin
                readWord = word3;
            end
            default:
            begin
                readWord = stepper_status_pkg::STATUS_RESET;
            end
        endcase
    end

    // A fault that arrives in the cycle of the clearing read still sets its flag.
    always_comb
    begin
        state_d          = state_q;
        state_d.rvalid   = regRead;
        state_d.ovcX     = (clearX ? stepper_status_pkg::OVC_RESET : state_q.ovcX) | ovcXNow;
        state_d.ovcY     = (clearY ? stepper_status_pkg::OVC_RESET : state_q.ovcY) | ovcYNow;
        state_d.hotStop  = (state_q.hotStop && !clearY) ||
                           faults.synced[stepper_status_pkg::S_SHUTDOWN];
        if (regRead)
        begin
            state_d.rdata = readWord;
        end
        // Reading never touches this flag, and an expiry beats a same-cycle clear.
        if (watchdogEnableWriteZero)
        begin
            state_d.dogEvent = 1'b0;
        end
        if (watchdogExpired)
        begin
            state_d.dogEvent = 1'b1;
        end
    end

    // Only power-on or hard reset reaches resetn; the watchdog reset does not.
    // A user must keep the watchdog reset off resetn, or warm and cold boots look alike.
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q.ovcX     <= stepper_status_pkg::OVC_RESET;
            state_q.ovcY     <= stepper_status_pkg::OVC_RESET;
            state_q.hotStop  <= 1'b0;
            state_q.dogEvent <= 1'b0;
            state_q.rdata    <= stepper_status_pkg::STATUS_RESET;
            state_q.rvalid   <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // There is no register write port; the one write that alters the bank is watchdogEnableWriteZero, which clears the watchdog flag.
    assign readData            = state_q.rdata;
    assign readValid           = state_q.rvalid;
    assign watchdog_event_flag = state_q.dogEvent;
endmodule : stepper_driver_status_bank

// ===== hw/stepper_status_pkg.sv
package stepper_status_pkg;

    localparam int unsigned ADDR_W    = 8;
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned STEP_W    = 7;
    localparam int unsigned SYNC_W    = 13;

    localparam logic [ADDR_W-1:0] FAULT_AND_WATCHDOG_STATUS_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] PHASE_X_OVERCURRENT_STATUS_OFS = 8'h05;
    localparam logic [ADDR_W-1:0] PHASE_Y_OVERCURRENT_STATUS_OFS = 8'h06;
    localparam logic [ADDR_W-1:0] STEP_POSITION_STATUS_OFS       = 8'h07;

    localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
    localparam logic [STEP_W-1:0] STEP_RESET   = 7'h00;
    localparam logic [3:0]        OVC_RESET    = 4'h0;

    localparam int unsigned PARITY_BIT = 7;
    localparam int unsigned WARN_BIT     = 6;
    localparam int unsigned PUMP_BIT     = 5;
    localparam int unsigned DOG_BIT      = 4;
    localparam int unsigned COIL_X_BIT   = 3;
    localparam int unsigned COIL_Y_BIT   = 2;
    localparam int unsigned OVC_LSB      = 3;
    localparam int unsigned SHUTDOWN_BIT = 2;

    localparam int unsigned S_WARN     = 0;
    localparam int unsigned S_PUMP     = 1;
    localparam int unsigned S_COIL_X   = 2;
    localparam int unsigned S_COIL_Y   = 3;
    localparam int unsigned S_OVCX     = 4;
    localparam int unsigned S_OVCY     = 8;
    localparam int unsigned S_SHUTDOWN = 12;

    localparam logic [SYNC_W-1:0] SYNC_RESET = 13'h0000;

endpackage : stepper_status_pkg

// ===== hw/fault_sync_if.sv
`timescale 1ns/1ps
interface fault_sync_if;
    logic [stepper_status_pkg::SYNC_W-1:0] raw;
    logic [stepper_status_pkg::SYNC_W-1:0] synced;

    modport syncer
    (
        input  raw,
        output synced
    );
    modport user
    (
        output raw,
        input  synced
    );
endinterface : fault_sync_if

// ===== hw/fault_synchronizer.sv
`timescale 1ns/1ps
module fault_synchronizer
(
    input  wire logic   clock,
    input  wire logic   resetn,
    fault_sync_if.syncer bus
);
    typedef struct packed
    {
        logic [stepper_status_pkg::SYNC_W-1:0] first;
        logic [stepper_status_pkg::SYNC_W-1:0] second;
    } sync_s;

    sync_s state_q;
    sync_s state_d;

    // The first stage feeds only the second, so metastability never reaches logic.
    always_comb
    begin
        state_d        = state_q;
        state_d.first  = bus.raw;
        state_d.second = state_q.first;
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= {stepper_status_pkg::SYNC_RESET, stepper_status_pkg::SYNC_RESET};
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign bus.synced = state_q.second;
endmodule : fault_synchronizer

// ===== tb/stepper_status_chk.sv
`timescale 1ns/1ps
module stepper_status_chk
(
    input wire logic       clock,
    input wire logic       resetn,
    input wire logic       regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] readData,
    input wire logic       readValid,
    input wire logic       watchdogExpired,
    input wire logic       watchdogEnableWriteZero,
    input wire logic [6:0] micro_step_position,
    input wire logic       watchdog_event_flag
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence readOf(logic [7:0] a);
        regRead && regAddr == a;
    endsequence
    sequence wdClear;
        watchdogEnableWriteZero && !watchdogExpired;
    endsequence
    a_reset_quiet: assert property (disable iff (1'b0) !resetn |-> readData == 8'h00 && !readValid)
        else $error("outputs not cleared in reset");
    a_read_answer: assert property (regRead |=> readValid)
        else $error("read not answered");
    a_no_stray: assert property (!regRead |=> !readValid)
        else $error("answer without read");
    a_parity_even: assert property (readValid |-> !(^readData))
        else $error("odd parity in read word");
    a_step_position: assert property (readOf(8'h07) |=> readData[6:0] == $past(micro_step_position))
        else $error("step position word wrong");
    a_unmapped_zero: assert property (regRead && (regAddr < 8'h04 || regAddr > 8'h07) |=> readData == 8'h00)
        else $error("unmapped read not zero");
    a_wd_sets: assert property (watchdogExpired |=> watchdog_event_flag)
        else $error("watchdog flag not set");
    a_wd_clears: assert property (wdClear |=> !watchdog_event_flag)
        else $error("watchdog flag not cleared");
    a_wd_survives: assert property (watchdog_event_flag && !watchdogEnableWriteZero |=> watchdog_event_flag)
        else $error("watchdog flag lost");
    a_wd_cause: assert property ($rose(watchdog_event_flag) |-> $past(watchdogExpired))
        else $error("watchdog flag rose without cause");
    a_wd_readback: assert property (readOf(8'h04) |=> readData[4] == $past(watchdog_event_flag))
        else $error("watchdog bit misreported");
endmodule : stepper_status_chk

// ===== tb/status_reader.sv
`timescale 1ns/1ps
module status_reader
(
    input  wire logic       clock,
    output logic            regRead,
    output logic [7:0]      regAddr,
    input  wire logic [7:0] readData,
    input  wire logic       readValid
);
    initial
    begin
        regRead = 1'b0;
        regAddr = 8'h00;
    end
    // The master only ever reads; the status bank offers it nothing to write.
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(posedge clock);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRead <= 1'b0;
        regAddr <= ~a;
        n = 0;
        #1;
        while (readValid !== 1'b1 && n < 4)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        d = (readValid === 1'b1) ? readData : 8'hxx;
    endtask : read_reg
endmodule : status_reader

// ===== tb/stepper_driver_status_bank_test.sv
`timescale 1ns/1ps
module stepper_driver_status_bank_test;
    logic clock, resetn, regRead, readValid, wdExp, wdZero, wdFlag;
    logic [7:0]  regAddr, readData;
    logic [12:0] flt;
    logic [6:0]  msp;
    int          miscompares, checkCount;
    stepper_driver_status_bank dut
    (
        .clock(clock), .resetn(resetn), .regRead(regRead), .regAddr(regAddr),
        .readData(readData), .readValid(readValid),
        .thermal_warning_flag(flt[0]), .charge_pump_failure_flag(flt[1]),
        .open_coil_x_flag(flt[2]), .open_coil_y_flag(flt[3]),
        .overcurrent_x_pos_top(flt[4]), .overcurrent_x_pos_bottom(flt[5]),
        .overcurrent_x_neg_top(flt[6]), .overcurrent_x_neg_bottom(flt[7]),
        .overcurrent_y_pos_top(flt[8]), .overcurrent_y_pos_bottom(flt[9]),
        .overcurrent_y_neg_top(flt[10]), .overcurrent_y_neg_bottom(flt[11]),
        .thermal_shutdown_flag(flt[12]), .watchdogExpired(wdExp),
        .watchdogEnableWriteZero(wdZero), .micro_step_position(msp), .watchdog_event_flag(wdFlag)
    );
    status_reader master
    (
        .clock(clock), .regRead(regRead), .regAddr(regAddr), .readData(readData),
        .readValid(readValid)
    );
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checkCount++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task read_check(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        master.read_reg(a, d);
        check(what, exp, d);
    endtask : read_check
    // Fault inputs cross a two-flop synchroniser, so give them three edges.
    task drive_faults(input logic [12:0] f);
        @(posedge clock) flt <= f;
        repeat (3) @(posedge clock);
    endtask : drive_faults
    task end_of_test;
        $display("checks %0d mismatches %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test
    task test_reset;
        for (int a = 3; a <= 8; a++) read_check("reset word", a[7:0], 8'h00);
        $display("test_reset done");
    endtask : test_reset
    task test_live;
        drive_faults(13'h000f);
        read_check("live all", 8'h04, 8'h6c);
        drive_faults(13'h0002);
        read_check("pump only", 8'h04, 8'ha0);
        drive_faults(13'h0000);
        read_check("pump gone", 8'h04, 8'h00);
        $display("test_live done");
    endtask : test_live
    // One-cycle fault pulses must still be caught, then cleared by the read.
    task test_latched;
        @(posedge clock) flt <= 13'h00f0;
        drive_faults(13'h0000);
        read_check("x latched", 8'h05, 8'h78);
        read_check("x cleared", 8'h05, 8'h00);
        @(posedge clock) flt <= 13'h1900;
        drive_faults(13'h0000);
        read_check("y latched", 8'h06, 8'hcc);
        read_check("y cleared", 8'h06, 8'h00);
        $display("test_latched done");
    endtask : test_latched
    task test_step;
        @(posedge clock) msp <= 7'h55;
        read_check("step even", 8'h07, 8'h55);
        @(posedge clock) msp <= 7'h01;
        read_check("step odd", 8'h07, 8'h81);
        $display("test_step done");
    endtask : test_step
    task test_watchdog;
        @(posedge clock) wdExp <= 1'b1;
        @(posedge clock) wdExp <= 1'b0;
        #1 check("wd set", 8'h01, {7'h00, wdFlag});
        read_check("wd read", 8'h04, 8'h90);
        read_check("wd kept", 8'h04, 8'h90);
        @(posedge clock) wdZero <= 1'b1;
        @(posedge clock) wdZero <= 1'b0;
        #1 check("wd clear", 8'h00, {7'h00, wdFlag});
        read_check("wd gone", 8'h04, 8'h00);
        $display("test_watchdog done");
    endtask : test_watchdog
    initial
    begin
        {flt, wdExp, wdZero, msp, miscompares, checkCount} = '0;
        resetn = 1'b1;
        // A definite falling edge clears the bank before the first clock edge.
        #10 resetn = 1'b0;
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        test_reset();
        test_live();
        test_latched();
        test_step();
        test_watchdog();
        end_of_test();
    end
    // The tests need about 70 cycles; the 1500-cycle limit, over twenty times that, means a hang.
    initial
    begin
        #150000;
        miscompares++;
        end_of_test();
    end
endmodule : stepper_driver_status_bank_test
bind stepper_driver_status_bank stepper_status_chk chk
(
    .clock(clock), .resetn(resetn), .regRead(regRead), .regAddr(regAddr),
    .readData(readData), .readValid(readValid), .watchdogExpired(watchdogExpired),
    .watchdogEnableWriteZero(watchdogEnableWriteZero),
    .micro_step_position(micro_step_position), .watchdog_event_flag(watchdog_event_flag)
);
